// [ccu_pkg.sv]
// ==========================================
// Capture/compare unit constants and types
package ccu_pkg;
    // ==========================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VLO = 8'h04;
    localparam logic [7:0] ADDR_VHI = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;

    // Field positions
    localparam int CTRL_DUTY_HI = 5;
    localparam int CTRL_DUTY_LO = 4;
    localparam int CFG_TSEL = 0;
    localparam int CFG_RXTS = 1;
    localparam int STAT_FLAG = 0;
    localparam int STAT_PIN = 1;

    // Reset values
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [15:0] VALUE_RST = 16'h0000;

    // Mode select codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAPCAN = 4'h3;
    localparam logic [3:0] MODE_CAPFALL = 4'h4;
    localparam logic [3:0] MODE_CAPRISE = 4'h5;
    localparam logic [3:0] MODE_CAP4 = 4'h6;
    localparam logic [3:0] MODE_CAP16 = 4'h7;
    localparam logic [3:0] MODE_SETHI = 4'h8;
    localparam logic [3:0] MODE_SETLO = 4'h9;
    localparam logic [3:0] MODE_SWINT = 4'ha;
    localparam logic [3:0] MODE_SPECIAL = 4'hb;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;

    // Prescaler terminal counts
    localparam logic [3:0] PS4_LAST = 4'h3;
    localparam logic [3:0] PS16_LAST = 4'hf;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timer pair inputs
    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
        logic firstWr;
        logic secondWr;
    } ccu_tmr_t;

    // Trigger outputs to timers and converter
    typedef struct packed {
        logic firstRst;
        logic secondRst;
        logic firstOvfMask;
        logic secondOvfMask;
        logic adcStart;
    } ccu_trg_t;
endpackage

// [ccu_top.sv]
`timescale 1ns/1ps
// Function
// - Mode 0000 turns unit off, resets state
// - 0100-0111: fall, rise, 4th, 16th rise
// - Mode 0011 captures on CAN receive
// - 1000: pin low on entry, high on match
// - 1001: pin high on entry, low on match
// - 0010: toggle pin on each match
// - 1010: match sets flag, pin untouched
// - 1011: match fires special event trigger
// - 11xx PWM; duty LSBs in control 5-4
// - Capture copies selected 16-bit timer
// - Flag set by capture, software clears
// - New capture overwrites unread value
// - Prescaler cleared when off or not capturing
// - Prescaler switch keeps partial count
// - Timestamp enable selects CAN event source
// - Compare continuously, act on equality
// - Select bit picks first or second timer
// - Control written zero forces latch low
// - Edge detect uses actual pin level
// - Trigger reset does not flag overflow
// - Timer write beats trigger reset
module ccu_top
    import ccu_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Event sources
    input wire logic eventPin,
    input wire logic canRxEvt,
    input wire logic adcEnable,
    input wire ccu_tmr_t timers,
    // Unit outputs
    output logic compareOut,
    output logic ccFlag,
    output logic pwmMode,
    output logic [9:0] dutyValue,
    output ccu_trg_t trg
);
    // ==========================================
    // Register state
    logic [5:0] ctrl_r;
    logic [1:0] cfg_r;
    logic [15:0] value_r;
    logic flag_r;
    logic pin_r;
    logic [3:0] psCnt_r;
    logic pinMeta_r;
    logic pinSync_r;
    logic srcPrev_r;
    logic matchPrev_r;
    ccu_trg_t trg_r;

    // Bus state
    logic awHeld_r;
    logic [7:0] awAddr_r;
    logic wHeld_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;

    // Decoded terms
    logic [3:0] mode;
    logic isCap, isCmp, isPwm;
    logic [15:0] timerVal;
    logic srcLvl, srcRise, srcFall;
    logic capEvt;
    logic match, matchEvt, specialEvt;
    logic doWrite;
    logic wrOk;
    logic wrCtrl, wrVlo, wrVhi, wrCfg, wrStat;

    // ==========================================
    // Mode decode
    assign mode = ctrl_r[3:0];
    assign isCap = (mode >= MODE_CAPCAN) && (mode <= MODE_CAP16);
    assign isCmp = (mode == MODE_TOGGLE) || (mode[3:2] == 2'h2);
    assign isPwm = (mode[3:2] == MODE_PWM_TOP);
    // Timer pair chosen by select bit
    assign timerVal = cfg_r[CFG_TSEL] ? timers.second : timers.first;

    // ==========================================
    // Event pin synchroniser, two stages
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pinMeta_r <= 1'b0;
            pinSync_r <= 1'b0;
        end else begin
            pinMeta_r <= eventPin;
            pinSync_r <= pinMeta_r;
        end
    end

    // Event source select and edge detect
    always_comb begin
        if (cfg_r[CFG_RXTS] || (mode == MODE_CAPCAN)) begin
            srcLvl = canRxEvt;
        end else begin
            srcLvl = pinSync_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            srcPrev_r <= 1'b0;
        end else begin
            srcPrev_r <= srcLvl;
        end
    end

    assign srcRise = srcLvl && !srcPrev_r;
    assign srcFall = !srcLvl && srcPrev_r;

    // ==========================================
    // Capture prescaler
    always_ff @(posedge clock) begin
        if (!rstn || !isCap) begin
            psCnt_r <= 4'h0;
        end else if (srcRise && (mode == MODE_CAP4)) begin
            psCnt_r <= (psCnt_r >= PS4_LAST) ? 4'h0 : psCnt_r + 4'h1;
        end else if (srcRise && (mode == MODE_CAP16)) begin
            psCnt_r <= (psCnt_r == PS16_LAST) ? 4'h0 : psCnt_r + 4'h1;
        end
    end

    // Capture event per mode
    always_comb begin
        case (mode)
            MODE_CAPCAN: capEvt = srcRise;
            MODE_CAPFALL: capEvt = srcFall;
            MODE_CAPRISE: capEvt = srcRise;
            MODE_CAP4: capEvt = srcRise && (psCnt_r >= PS4_LAST);
            MODE_CAP16: capEvt = srcRise && (psCnt_r == PS16_LAST);
            default: capEvt = 1'b0;
        endcase
    end

    // ==========================================
    // Compare match, one event per equality
    assign match = isCmp && (value_r == timerVal);
    assign matchEvt = match && !matchPrev_r;
    assign specialEvt = matchEvt && (mode == MODE_SPECIAL);

    always_ff @(posedge clock) begin
        if (!rstn || !isCmp) begin
            matchPrev_r <= 1'b0;
        end else begin
            matchPrev_r <= match;
        end
    end

    // ==========================================
    // Bus write path
    assign awready = !awHeld_r && !bvalid_r;
    assign wready = !wHeld_r && !bvalid_r;
    assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
    assign wrOk = doWrite && wStrb_r[0];
    assign wrCtrl = wrOk && (awAddr_r == ADDR_CTRL);
    assign wrVlo = wrOk && (awAddr_r == ADDR_VLO);
    assign wrVhi = wrOk && (awAddr_r == ADDR_VHI);
    assign wrCfg = wrOk && (awAddr_r == ADDR_CFG);
    assign wrStat = wrOk && (awAddr_r == ADDR_STAT);

    // Address and data holding
    always_ff @(posedge clock) begin
        if (!rstn) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wHeld_r <= 1'b0;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
        end else if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
        end
    end

    // Write response, error on unmapped address
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid_r <= 1'b1;
            if (awAddr_r == ADDR_CTRL || awAddr_r == ADDR_VLO || awAddr_r == ADDR_VHI
                || awAddr_r == ADDR_CFG || awAddr_r == ADDR_STAT) begin
                bresp_r <= RESP_OKAY;
            end else begin
                bresp_r <= RESP_SLVERR;
            end
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    // ==========================================
    // Control and configuration registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
            cfg_r <= CFG_RST;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= wData_r[5:0];
            end
            if (wrCfg) begin
                cfg_r <= wData_r[1:0];
            end
        end
    end

    // Value register: capture beats software write
    always_ff @(posedge clock) begin
        if (!rstn) begin
            value_r <= VALUE_RST;
        end else if (capEvt) begin
            value_r <= timerVal;
        end else begin
            if (wrVlo) begin
                value_r[7:0] <= wData_r[7:0];
            end
            if (wrVhi && !isPwm) begin
                value_r[15:8] <= wData_r[7:0];
            end
        end
    end

    // Flag: set wins over software clear
    always_ff @(posedge clock) begin
        if (!rstn) begin
            flag_r <= 1'b0;
        end else if (capEvt || matchEvt) begin
            flag_r <= 1'b1;
        end else if (wrStat && wData_r[STAT_FLAG]) begin
            flag_r <= 1'b0;
        end
    end

    // ==========================================
    // Compare output latch
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pin_r <= 1'b0;
        end else if (wrCtrl && (wData_r[7:0] == 8'h00)) begin
            pin_r <= 1'b0;
        end else if (wrCtrl && (wData_r[3:0] != mode)) begin
            case (wData_r[3:0])
                MODE_OFF: pin_r <= 1'b0;
                MODE_SETHI: pin_r <= 1'b0;
                MODE_SETLO: pin_r <= 1'b1;
                default: pin_r <= pin_r;
            endcase
        end else if (matchEvt) begin
            case (mode)
                MODE_SETHI: pin_r <= 1'b1;
                MODE_SETLO: pin_r <= 1'b0;
                MODE_TOGGLE: pin_r <= !pin_r;
                default: pin_r <= pin_r;
            endcase
        end
    end

    // ==========================================
    // Special event trigger outputs
    always_ff @(posedge clock) begin
        if (!rstn) begin
            trg_r <= '0;
        end else begin
            trg_r.firstRst <= specialEvt && !cfg_r[CFG_TSEL] && !timers.firstWr;
            trg_r.secondRst <= specialEvt && cfg_r[CFG_TSEL] && !timers.secondWr;
            trg_r.firstOvfMask <= specialEvt && !cfg_r[CFG_TSEL];
            trg_r.secondOvfMask <= specialEvt && cfg_r[CFG_TSEL];
            trg_r.adcStart <= specialEvt && adcEnable;
        end
    end

    assign trg = trg_r;
    assign compareOut = pin_r;
    assign ccFlag = flag_r;
    assign pwmMode = isPwm;
    assign dutyValue = {value_r[7:0], ctrl_r[CTRL_DUTY_HI:CTRL_DUTY_LO]};

    // ==========================================
    // Bus read path
    assign arready = !rvalid_r;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            if (araddr == ADDR_CTRL) begin
                rdata_r <= {26'h0, ctrl_r};
            end else if (araddr == ADDR_VLO) begin
                rdata_r <= {24'h000000, value_r[7:0]};
            end else if (araddr == ADDR_VHI) begin
                rdata_r <= {24'h000000, value_r[15:8]};
            end else if (araddr == ADDR_CFG) begin
                rdata_r <= {30'h0, cfg_r};
            end else if (araddr == ADDR_STAT) begin
                rdata_r <= {30'h0, pin_r, flag_r};
            end else begin
                rdata_r <= 32'h00000000;
                rresp_r <= RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;

    // ==========================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    chk_off_clears_ps: assert property (mode == MODE_OFF |=> psCnt_r == 4'h0)
        else $error("prescaler not cleared while off");
    chk_rise_capture: assert property (mode == MODE_CAPRISE && srcRise |=> flag_r)
        else $error("rising edge did not set flag");
    chk_capture_value: assert property (capEvt |=> value_r == $past(timerVal))
        else $error("capture did not load timer");
    chk_sethi_match: assert property (matchEvt && mode == MODE_SETHI && !wrCtrl
        |=> pin_r && flag_r)
        else $error("set-high match wrong");
    chk_setlo_match: assert property (matchEvt && mode == MODE_SETLO && !wrCtrl
        |=> !pin_r && flag_r)
        else $error("set-low match wrong");
    chk_toggle_match: assert property (matchEvt && mode == MODE_TOGGLE && !wrCtrl
        |=> pin_r != $past(pin_r))
        else $error("toggle match did not invert");
    chk_swint_pin: assert property (mode == MODE_SWINT && !wrCtrl |=> $stable(pin_r))
        else $error("pin moved in flag-only mode");
    chk_special_trig: assert property (specialEvt && !cfg_r[CFG_TSEL] && !timers.firstWr
        |=> trg.firstRst && trg.firstOvfMask)
        else $error("special trigger missing");
    chk_write_wins: assert property (timers.firstWr |=> !trg.firstRst)
        else $error("reset beat timer write");
    chk_zero_ctrl: assert property (wrCtrl && wData_r[7:0] == 8'h00 |=> !pin_r)
        else $error("latch not low after zero write");
    chk_div4_count: assert property (mode == MODE_CAP4 && srcRise && psCnt_r < PS4_LAST
        && !wrCtrl |=> psCnt_r == $past(psCnt_r) + 4'h1)
        else $error("divide by four miscounted");
    chk_flag_sticky: assert property (flag_r && !(wrStat && wData_r[STAT_FLAG])
        |=> flag_r)
        else $error("flag cleared without software");
endmodule

// [ccu_far_model.sv]
`timescale 1ns/1ps
// ==========================================
// Timer pairs seen by the unit
module ccu_far_model
    import ccu_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Bench controls
    input wire logic freeze,
    input wire logic loadFirst,
    input wire logic loadSecond,
    input wire logic [15:0] loadVal,
    // Unit side
    input wire ccu_trg_t trg,
    output ccu_tmr_t timers
);
    logic [15:0] firstCnt_r;
    logic [15:0] secondCnt_r;

    // First pair: write beats trigger, counts on the system clock
    always_ff @(posedge clock) begin
        if (!rstn) begin
            firstCnt_r <= 16'h0000;
        end else if (loadFirst) begin
            firstCnt_r <= loadVal;
        end else if (trg.firstRst) begin
            firstCnt_r <= 16'h0000;
        end else if (!freeze) begin
            firstCnt_r <= firstCnt_r + 16'h0001;
        end
    end

    // Second pair, same behaviour
    always_ff @(posedge clock) begin
        if (!rstn) begin
            secondCnt_r <= 16'h0000;
        end else if (loadSecond) begin
            secondCnt_r <= loadVal;
        end else if (trg.secondRst) begin
            secondCnt_r <= 16'h0000;
        end else if (!freeze) begin
            secondCnt_r <= secondCnt_r + 16'h0001;
        end
    end

    // Counts and write strobes to the unit
    assign timers.first = firstCnt_r;
    assign timers.second = secondCnt_r;
    assign timers.firstWr = loadFirst;
    assign timers.secondWr = loadSecond;
endmodule

// [capture_compare_unit_test.sv]
`timescale 1ns/1ps
// ==========================================
// Self-checking bench
module capture_compare_unit_test
    import ccu_pkg::*;
;
    logic clock = 1'b0;
    logic rstn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, lastResp;
    logic eventPin, canRxEvt, adcEnable, compareOut, ccFlag, pwmMode;
    logic freeze, loadFirst, loadSecond;
    logic [15:0] loadVal;
    logic [9:0] dutyValue;
    logic [31:0] rv;
    ccu_tmr_t timers;
    ccu_trg_t trg;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int trgCount = 0;
    int adcCount = 0;

    always #2.5 clock = ~clock;

    ccu_top dut (.clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .eventPin(eventPin), .canRxEvt(canRxEvt), .adcEnable(adcEnable), .timers(timers),
        .compareOut(compareOut), .ccFlag(ccFlag), .pwmMode(pwmMode),
        .dutyValue(dutyValue), .trg(trg));

    ccu_far_model far (.clock(clock), .rstn(rstn), .freeze(freeze), .loadFirst(loadFirst),
        .loadSecond(loadSecond), .loadVal(loadVal), .trg(trg), .timers(timers));

    // Trigger pulse counters and hang guard
    always @(posedge clock) begin
        cycles++;
        if (trg.firstRst === 1'b1 && trg.firstOvfMask === 1'b1) trgCount++;
        if (trg.adcStart === 1'b1) adcCount++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    task final_report();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ==========================================
    // Register bus master
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!done) begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                lastResp = bresp;
                done = 1'b1;
            end
        end
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!done) begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                lastResp = rresp;
                done = 1'b1;
            end
        end
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, rv);
        chk(rv, exp);
    endtask

    // ==========================================
    // Far side stimulus
    task pinPulse(input int n);
        repeat (n) begin
            eventPin <= 1'b1;
            tick(6);
            eventPin <= 1'b0;
            tick(6);
        end
    endtask

    task canPulse();
        canRxEvt <= 1'b1;
        tick(1);
        canRxEvt <= 1'b0;
        tick(4);
    endtask

    task loadT(input logic sec, input logic [15:0] v);
        loadVal <= v;
        loadFirst <= !sec;
        loadSecond <= sec;
        tick(1);
        loadFirst <= 1'b0;
        loadSecond <= 1'b0;
        tick(1);
    endtask

    // ==========================================
    // Scenarios
    task t_reset();
        logic [7:0] regs [5];
        regs = '{ADDR_CTRL, ADDR_VLO, ADDR_VHI, ADDR_CFG, ADDR_STAT};
        foreach (regs[i]) rdchk(regs[i], 32'h0);
        rdchk(8'h14, 32'h0);
        chk(lastResp, RESP_SLVERR);
        wr(8'h14, 32'h1);
        chk(lastResp, RESP_SLVERR);
    endtask

    task t_capture();
        logic [3:0] m [4];
        int n [4];
        logic [15:0] v;
        m = '{MODE_CAPFALL, MODE_CAPRISE, MODE_CAP4, MODE_CAP16};
        n = '{1, 1, 4, 16};
        for (int i = 0; i < 4; i++) begin
            v = 16'h4321 + 16'(i);
            wr(ADDR_CTRL, 32'h0);
            wr(ADDR_CTRL, {28'h0, m[i]});
            wr(ADDR_STAT, 32'h1);
            loadT(1'b0, v);
            if (n[i] > 1) pinPulse(n[i] - 1);
            eventPin <= 1'b1;
            tick(8);
            chk(ccFlag, (m[i] != MODE_CAPFALL));
            pinPulse(1);
            chk(ccFlag, 1'b1);
            rdchk(ADDR_VLO, {24'h0, v[7:0]});
            rdchk(ADDR_VHI, {24'h0, v[15:8]});
            chk(ccFlag, 1'b1);
        end
        wr(ADDR_STAT, 32'h1);
        chk(ccFlag, 1'b0);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, {28'h0, MODE_CAPRISE});
        loadT(1'b0, 16'h1111);
        pinPulse(1);
        loadT(1'b0, 16'h2222);
        pinPulse(1);
        rdchk(ADDR_VLO, 32'h22);
        wr(ADDR_CFG, 32'h1);
        loadT(1'b1, 16'hbeef);
        pinPulse(1);
        rdchk(ADDR_VHI, 32'hbe);
        rdchk(ADDR_VLO, 32'hef);
        wr(ADDR_CFG, 32'h2);
        wr(ADDR_STAT, 32'h1);
        pinPulse(1);
        chk(ccFlag, 1'b0);
        canPulse();
        chk(ccFlag, 1'b1);
        rdchk(ADDR_VLO, 32'h22);
        wr(ADDR_CFG, 32'h0);
        wr(ADDR_CTRL, {28'h0, MODE_CAPCAN});
        wr(ADDR_STAT, 32'h1);
        loadT(1'b0, 16'h3303);
        canPulse();
        rdchk(ADDR_VLO, 32'h03);
    endtask

    task cmpMode(input logic [3:0] m, input logic pre, input logic post, input logic pin);
        loadT(1'b0, 16'h0100);
        wr(ADDR_VLO, 32'h00);
        wr(ADDR_VHI, 32'h02);
        wr(ADDR_CTRL, {28'h0, m});
        wr(ADDR_STAT, 32'h1);
        if (pin) chk(compareOut, pre);
        loadT(1'b0, 16'h0200);
        tick(3);
        chk(ccFlag, 1'b1);
        if (pin) chk(compareOut, post);
    endtask

    task t_compare();
        cmpMode(MODE_SETHI, 1'b0, 1'b1, 1'b1);
        cmpMode(MODE_SETLO, 1'b1, 1'b0, 1'b1);
        cmpMode(MODE_SWINT, 1'b0, 1'b0, 1'b1);
        cmpMode(MODE_TOGGLE, 1'b0, 1'b1, 1'b1);
        cmpMode(MODE_SPECIAL, 1'b0, 1'b0, 1'b0);
        chk(trgCount, 1);
        chk(adcCount, 1);
        chk(timers.first, 16'h0000);
        // Second pair trigger with converter disabled
        adcEnable <= 1'b0;
        wr(ADDR_CFG, 32'h1);
        wr(ADDR_STAT, 32'h1);
        loadT(1'b1, 16'h0200);
        tick(3);
        chk(ccFlag, 1'b1);
        chk(timers.second, 16'h0000);
        chk(adcCount, 1);
        wr(ADDR_CTRL, {28'h0, MODE_SETLO});
        chk(compareOut, 1'b1);
        wr(ADDR_CTRL, 32'h0);
        chk(compareOut, 1'b0);
    endtask

    task t_pwm();
        wr(ADDR_CTRL, 32'h3c);
        wr(ADDR_VLO, 32'ha5);
        wr(ADDR_VHI, 32'h77);
        chk(pwmMode, 1'b1);
        chk(dutyValue, 10'h297);
        rdchk(ADDR_VHI, 32'h02);
        rdchk(ADDR_CTRL, 32'h3c);
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        {awvalid, wvalid, arvalid} = 3'h0;
        {bready, rready} = 2'h3;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        {eventPin, canRxEvt, loadFirst, loadSecond} = 4'h0;
        adcEnable = 1'b1;
        freeze = 1'b1;
        loadVal = 16'h0000;
        tick(5);
        rstn <= 1'b1;
        tick(1);
        t_reset();
        t_capture();
        t_compare();
        t_pwm();
        final_report();
    end
endmodule
